/* hw/lpa_line_timing.sv */
// Line-locked PLL setup, active video window and copy guard stripper
// Notes on behaviour
// - Divider is 12 bits, high byte plus nibble
// - VCO range code sits in bits 7:6
// - Charge pump current code sits in bits 5:3
// - Output divider control is bit 0 of 04h
// - Pixel positions count from negative sync edge
// - Stripping is enabled by a bit in 22h
// - Width in 34h masks pulses outside sync window
// - Stripper window counts reference clock cycles
// - Width only affects the status window bit while stripping is disabled
module lpa_line_timing
  import lpa_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = SLAVE_ADDR_DEF
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         scl_in,
  input  wire logic         sda_in,
  output logic              sda_out,
  output logic              sda_oe,
  input  wire logic         sync_n_in,
  input  wire logic         reference_clock,
  output lpa_pll_cfg_s      pll_cfg,
  output lpa_vblank_s       vertical_blank,
  output logic [7:0]        output_format,
  output logic [POS_W-1:0]  pixel_count,
  output logic              active_video_window,
  output logic              sync_clean_n
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic scl_m;
  logic scl_s;
  logic scl_d;
  logic sda_m;
  logic sda_s;
  logic sda_d;
  logic hs_m;
  logic hs_s;
  logic hs_d;
  logic rc_m;
  logic rc_s;
  logic rc_d;

  always_ff @(posedge clk) begin
    if (reset) begin
      {scl_m, scl_s, scl_d} <= 3'h7;
      {sda_m, sda_s, sda_d} <= 3'h7;
      {hs_m, hs_s, hs_d}    <= 3'h7;
      {rc_m, rc_s, rc_d}    <= 3'h0;
    end else begin
      {scl_m, scl_s, scl_d} <= {scl_in, scl_m, scl_s};
      {sda_m, sda_s, sda_d} <= {sda_in, sda_m, sda_s};
      {hs_m, hs_s, hs_d}    <= {sync_n_in, hs_m, hs_s};
      {rc_m, rc_s, rc_d}    <= {reference_clock, rc_m, rc_s};
    end
  end

  wire scl_rise  = scl_s & ~scl_d;
  wire scl_fall  = ~scl_s & scl_d;
  wire i2c_start = scl_s & scl_d & sda_d & ~sda_s;
  wire i2c_stop  = scl_s & scl_d & ~sda_d & sda_s;
  wire sync_fall = hs_d & ~hs_s;
  wire ref_tick  = rc_s & ~rc_d;

  // ****************************************************************
  // Register file
  // ****************************************************************
  function automatic logic is_writable(input logic [7:0] a);
    unique case (a)
      REG_DIV_HIGH, REG_DIV_LOW, REG_RANGE_PUMP, REG_OUT_DIVIDER,
      REG_OUT_FORMAT, REG_STRIP_CTRL, REG_STRIP_WIDTH,
      REG_START_LOW, REG_START_HIGH, REG_STOP_LOW, REG_STOP_HIGH,
      REG_VB_F0_OFFSET, REG_VB_F1_OFFSET, REG_VB_F0_DUR, REG_VB_F1_DUR,
      REG_F0_FLAG, REG_F1_FLAG: is_writable = 1'b1;
      default:                  is_writable = 1'b0;
    endcase
  endfunction : is_writable

  logic [7:0]  reg_mem [0:NUM_REGS-1];
  lpa_i2c_e    st;
  lpa_i2c_e    nxt;
  logic [3:0]  bit_cnt;
  logic [7:0]  shift;
  logic [7:0]  sub;
  logic        nack;
  logic        win_open;

  wire       byte_done = (bit_cnt == BITS_PER_BYTE);
  wire       wr_fire   = (st == I2C_WRITE) && scl_fall && byte_done;
  wire [7:0] status_byte = (8'(active_video_window) << STAT_ACT_BIT)
                         | (8'(win_open) << STAT_WIN_BIT);
  wire [7:0] rd_data = (sub == REG_STATUS) ? status_byte
                     : (is_writable(sub) ? reg_mem[sub] : RESET_BYTE);

  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        reg_mem[i] <= RESET_BYTE;
      end
    end else if (wr_fire && is_writable(sub)) begin
      reg_mem[sub] <= shift;
    end
  end

  // ****************************************************************
  // Serial register port
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      st      <= I2C_IDLE;
      nxt     <= I2C_IDLE;
      bit_cnt <= 4'h0;
      shift   <= RESET_BYTE;
      sub     <= RESET_BYTE;
      nack    <= 1'b0;
      sda_oe  <= 1'b0;
      sda_out <= 1'b0;
    end else if (i2c_start) begin
      st      <= I2C_ADDR;
      bit_cnt <= 4'h0;
      sda_oe  <= 1'b0;
    end else if (i2c_stop) begin
      st     <= I2C_IDLE;
      sda_oe <= 1'b0;
    end else begin
      unique case (st)
        I2C_IDLE: begin
          bit_cnt <= 4'h0;
        end
        I2C_ADDR, I2C_SUB, I2C_WRITE: begin
          if (scl_rise) begin
            shift   <= {shift[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && byte_done) begin
            bit_cnt <= 4'h0;
            st      <= I2C_ACK;
            sda_oe  <= 1'b1;
            if (st == I2C_ADDR) begin
              nxt <= shift[0] ? I2C_READ : I2C_SUB;
              if (shift[7:1] != SLAVE_ADDR) begin
                st     <= I2C_IDLE;
                sda_oe <= 1'b0;
              end
            end else if (st == I2C_SUB) begin
              sub <= shift;
              nxt <= I2C_WRITE;
            end else begin
              sub <= sub + 8'h1;
              nxt <= I2C_WRITE;
            end
          end
        end
        I2C_ACK: begin
          if (scl_fall) begin
            st <= nxt;
            if (nxt == I2C_READ) begin
              shift  <= rd_data;
              sda_oe <= ~rd_data[7];
              sub    <= sub + 8'h1;
            end else begin
              sda_oe <= 1'b0;
            end
          end
        end
        I2C_READ: begin
          if (scl_fall) begin
            if (bit_cnt == LAST_READ_BIT) begin
              bit_cnt <= 4'h0;
              sda_oe  <= 1'b0;
              st      <= I2C_RACK;
            end else begin
              shift   <= {shift[6:0], 1'b0};
              sda_oe  <= ~shift[6];
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        I2C_RACK: begin
          if (scl_rise) begin
            nack <= sda_s;
          end else if (scl_fall) begin
            if (nack) begin
              st <= I2C_IDLE;
            end else begin
              st     <= I2C_READ;
              shift  <= rd_data;
              sda_oe <= ~rd_data[7];
              sub    <= sub + 8'h1;
            end
          end
        end
        default: begin
          st     <= I2C_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Configuration decode
  // ****************************************************************
  lpa_pll_cfg_s next_cfg;
  lpa_vblank_s  next_vblank;

  assign next_cfg.line_pixel_divider  = {reg_mem[REG_DIV_HIGH],
                                         reg_mem[REG_DIV_LOW][7:4]};
  assign next_cfg.vco_range           = lpa_vco_e'(reg_mem[REG_RANGE_PUMP][VCO_LSB +: 2]);
  assign next_cfg.charge_pump_current = reg_mem[REG_RANGE_PUMP][PUMP_LSB +: 3];
  assign next_cfg.output_divider      = reg_mem[REG_OUT_DIVIDER][OUT_DIV_BIT];
  assign next_cfg.copy_guard_strip_enable = reg_mem[REG_STRIP_CTRL][STRIP_EN_BIT];
  assign next_cfg.stripper_width      = reg_mem[REG_STRIP_WIDTH];
  assign next_vblank = {reg_mem[REG_VB_F0_OFFSET], reg_mem[REG_VB_F1_OFFSET],
                        reg_mem[REG_VB_F0_DUR], reg_mem[REG_VB_F1_DUR],
                        reg_mem[REG_F0_FLAG], reg_mem[REG_F1_FLAG]};

  wire [POS_W-1:0] act_start = {reg_mem[REG_START_HIGH][3:0], reg_mem[REG_START_LOW]};
  wire [POS_W-1:0] act_stop  = {reg_mem[REG_STOP_HIGH][3:0], reg_mem[REG_STOP_LOW]};

  always_ff @(posedge clk) begin
    if (reset) begin
      pll_cfg        <= '0;
      vertical_blank <= '0;
      output_format  <= RESET_BYTE;
    end else begin
      pll_cfg        <= next_cfg;
      vertical_blank <= next_vblank;
      output_format  <= reg_mem[REG_OUT_FORMAT];
    end
  end

  // ****************************************************************
  // Stripper window and pixel counter
  // ****************************************************************
  logic [7:0] ref_cnt;

  wire strip_on  = pll_cfg.copy_guard_strip_enable;
  wire line_end  = (pixel_count == pll_cfg.line_pixel_divider - 12'h1);
  wire sync_ok   = sync_fall & (win_open | ~strip_on);
  wire wrapped   = (act_stop < act_start);
  wire in_active = wrapped ? (pixel_count >= act_start || pixel_count < act_stop)
                           : (pixel_count >= act_start && pixel_count < act_stop);

  always_ff @(posedge clk) begin
    if (reset) begin
      win_open <= 1'b1;
      ref_cnt  <= 8'h0;
    end else if (line_end) begin
      win_open <= 1'b1;
      ref_cnt  <= 8'h0;
    end else if (win_open && ref_tick) begin
      ref_cnt <= ref_cnt + 8'h1;
      if (ref_cnt >= pll_cfg.stripper_width) begin
        win_open <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pixel_count         <= '0;
      active_video_window <= 1'b0;
      sync_clean_n        <= 1'b1;
    end else begin
      if (sync_ok || line_end) begin
        pixel_count <= '0;
      end else begin
        pixel_count <= pixel_count + 12'h1;
      end
      active_video_window <= in_active;
      sync_clean_n        <= hs_s | (strip_on & ~win_open);
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_sync_taken;
    sync_fall && (win_open || !strip_on);
  endsequence

  property p_divider_split;
    ##1 pll_cfg.line_pixel_divider[3:0] == $past(reg_mem[REG_DIV_LOW][7:4]);
  endproperty
  a_divider_split: assert property (p_divider_split) else $error("divider split wrong");

  property p_vco_field;
    ##1 pll_cfg.vco_range == lpa_vco_e'($past(reg_mem[REG_RANGE_PUMP][VCO_LSB +: 2]));
  endproperty
  a_vco_field: assert property (p_vco_field) else $error("vco range field wrong");

  property p_pump_field;
    ##1 pll_cfg.charge_pump_current == $past(reg_mem[REG_RANGE_PUMP][PUMP_LSB +: 3]);
  endproperty
  a_pump_field: assert property (p_pump_field) else $error("pump field wrong");

  property p_out_div;
    ##1 pll_cfg.output_divider == $past(reg_mem[REG_OUT_DIVIDER][OUT_DIV_BIT]);
  endproperty
  a_out_div: assert property (p_out_div) else $error("output divider wrong");

  property p_sync_zero;
    s_sync_taken |=> pixel_count == '0 ##1 pixel_count == 12'h1 || $past(line_end);
  endproperty
  a_sync_zero: assert property (p_sync_zero) else $error("count not zeroed");

  property p_active;
    ##1 active_video_window == $past(in_active);
  endproperty
  a_active: assert property (p_active) else $error("active window wrong");

  property p_strip_off;
    !strip_on |=> sync_clean_n == $past(hs_s);
  endproperty
  a_strip_off: assert property (p_strip_off) else $error("strip off not pass");

  property p_strip_mask;
    strip_on && !win_open |=> sync_clean_n;
  endproperty
  a_strip_mask: assert property (p_strip_mask) else $error("pulse not masked");

  property p_ref_count;
    win_open && !ref_tick && !line_end |=> $stable(ref_cnt);
  endproperty
  a_ref_count: assert property (p_ref_count) else $error("window count moved");

endmodule : lpa_line_timing

/* hw/lpa_pkg.sv */
// Register map, field layout and carrier types of the line timing block
package lpa_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] REG_DIV_HIGH     = 8'h01;
  localparam logic [7:0] REG_DIV_LOW      = 8'h02;
  localparam logic [7:0] REG_RANGE_PUMP   = 8'h03;
  localparam logic [7:0] REG_OUT_DIVIDER  = 8'h04;
  localparam logic [7:0] REG_OUT_FORMAT   = 8'h15;
  localparam logic [7:0] REG_STRIP_CTRL   = 8'h22;
  localparam logic [7:0] REG_STRIP_WIDTH  = 8'h34;
  localparam logic [7:0] REG_START_LOW    = 8'h40;
  localparam logic [7:0] REG_START_HIGH   = 8'h41;
  localparam logic [7:0] REG_STOP_LOW     = 8'h42;
  localparam logic [7:0] REG_STOP_HIGH    = 8'h43;
  localparam logic [7:0] REG_VB_F0_OFFSET = 8'h44;
  localparam logic [7:0] REG_VB_F1_OFFSET = 8'h45;
  localparam logic [7:0] REG_VB_F0_DUR    = 8'h46;
  localparam logic [7:0] REG_VB_F1_DUR    = 8'h47;
  localparam logic [7:0] REG_F0_FLAG      = 8'h48;
  localparam logic [7:0] REG_F1_FLAG      = 8'h49;
  localparam logic [7:0] REG_STATUS       = 8'h50;

  // ****************************************************************
  // Fields, widths and reset values
  // ****************************************************************
  localparam int         DIV_W          = 12;
  localparam int         POS_W          = 12;
  localparam int         VCO_LSB        = 6;
  localparam int         PUMP_LSB       = 3;
  localparam int         OUT_DIV_BIT    = 0;
  localparam int         STRIP_EN_BIT   = 0;
  localparam int         STAT_ACT_BIT   = 0;
  localparam int         STAT_WIN_BIT   = 1;
  localparam int         NUM_REGS       = 256;
  localparam logic [7:0] RESET_BYTE     = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
  localparam logic [3:0] LAST_READ_BIT  = 4'h7;
  // Arbitrary value, not tied to any product
  localparam logic [6:0] SLAVE_ADDR_DEF = 7'h2a;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    VCO_ULTRA_LOW = 2'b00,
    VCO_LOW       = 2'b01,
    VCO_MEDIUM    = 2'b10,
    VCO_HIGH      = 2'b11
  } lpa_vco_e;

  typedef enum logic [2:0] {
    I2C_IDLE  = 3'b000,
    I2C_ADDR  = 3'b001,
    I2C_SUB   = 3'b010,
    I2C_WRITE = 3'b011,
    I2C_ACK   = 3'b100,
    I2C_READ  = 3'b101,
    I2C_RACK  = 3'b110
  } lpa_i2c_e;

  typedef struct packed {
    logic [DIV_W-1:0] line_pixel_divider;
    lpa_vco_e         vco_range;
    logic [2:0]       charge_pump_current;
    logic             output_divider;
    logic             copy_guard_strip_enable;
    logic [7:0]       stripper_width;
  } lpa_pll_cfg_s;

  typedef struct packed {
    logic [7:0] field0_offset;
    logic [7:0] field1_offset;
    logic [7:0] field0_duration;
    logic [7:0] field1_duration;
    logic [7:0] field0_flag;
    logic [7:0] field1_flag;
  } lpa_vblank_s;

endpackage : lpa_pkg

/* verification/lpa_host_model.sv */
// Serial host model that programs and reads back the line timing registers
module lpa_host_model
  import lpa_pkg::*;
(
  input  wire logic clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // Data set while scl is low, line sampled mid high phase
  task automatic bit_cycle(input logic b, output logic seen);
    tick(1);
    sda_low <= ~b;
    tick(4);
    scl <= 1'b1;
    tick(3);
    seen = sda_line;
    tick(2);
    scl <= 1'b0;
  endtask : bit_cycle

  task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx,
                      output logic ack);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(tx[i], rx[i]);
    end
    bit_cycle(last, seen);
    ack = ~seen;
  endtask : xfer

  task automatic start_cond;
    tick(1);
    sda_low <= 1'b0;
    tick(4);
    scl <= 1'b1;
    tick(5);
    sda_low <= 1'b1;
    tick(5);
    scl <= 1'b0;
  endtask : start_cond

  task automatic stop_cond;
    tick(1);
    sda_low <= 1'b1;
    tick(4);
    scl <= 1'b1;
    tick(5);
    sda_low <= 1'b0;
    tick(5);
  endtask : stop_cond

  task automatic write_reg(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d,
                           output logic ok);
    logic [7:0] rx;
    logic       k0, k1, k2;
    start_cond();
    xfer({dev, 1'b0}, 1'b1, rx, k0);
    xfer(a, 1'b1, rx, k1);
    xfer(d, 1'b1, rx, k2);
    stop_cond();
    ok = k0 & k1 & k2;
  endtask : write_reg

  task automatic read_reg(input logic [6:0] dev, input logic [7:0] a, output logic [7:0] d,
                          output logic ok);
    logic [7:0] rx;
    logic       k0, k1, k2, k3;
    start_cond();
    xfer({dev, 1'b0}, 1'b1, rx, k0);
    xfer(a, 1'b1, rx, k1);
    start_cond();
    xfer({dev, 1'b1}, 1'b1, rx, k2);
    xfer(8'hff, 1'b1, d, k3);
    stop_cond();
    ok = k0 & k1 & k2;
  endtask : read_reg
endmodule : lpa_host_model

/* verification/test_line_pll_active_window_cfg.sv */
// Self-checking bench for the line timing block
module test_line_pll_active_window_cfg
  import lpa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************
  // Setup
  // ****************************************
  localparam logic [11:0] DIV = 12'h028;
  localparam logic [11:0] ST  = 12'h002 + 12'h003 + 12'h005;
  localparam logic [11:0] SP  = ST + 12'h006 + 12'h004;
  localparam logic [11:0] ST2 = 12'h01e;
  localparam logic [11:0] SP2 = ST2 + 12'h00b + 12'h004 - DIV;
  logic              clk, reset, scl, sda_low, ok, sda_out, sda_oe;
  logic              sync_n_in = 1'b1;
  logic              reference_clock = 1'b0;
  logic              ref_run = 1'b1;
  logic              mon_on = 1'b0;
  logic              active_video_window, sync_clean_n;
  lpa_pll_cfg_s      pll_cfg;
  lpa_vblank_s       vertical_blank;
  logic [7:0]        output_format, rd;
  logic [11:0]       pixel_count, prev_cnt, ws, we;
  int                num_errors = 0;
  int                check_count = 0;
  wire logic         sda_line = ~(sda_low | sda_oe);
  logic [23:0]       rows [18] = '{
    {REG_DIV_HIGH, 8'h02, 8'h02}, {REG_DIV_LOW, 8'h80, 8'h80}, {REG_RANGE_PUMP, 8'h18, 8'h18},
    {REG_OUT_DIVIDER, 8'h01, 8'h01}, {REG_OUT_FORMAT, 8'h47, 8'h47},
    {REG_STRIP_CTRL, 8'h00, 8'h00}, {REG_STRIP_WIDTH, 8'h03, 8'h03},
    {REG_START_LOW, ST[7:0], ST[7:0]}, {REG_START_HIGH, 8'h00, 8'h00},
    {REG_STOP_LOW, SP[7:0], SP[7:0]}, {REG_STOP_HIGH, 8'h00, 8'h00},
    {REG_VB_F0_OFFSET, 8'h05, 8'h05}, {REG_VB_F1_OFFSET, 8'h06, 8'h06},
    {REG_VB_F0_DUR, 8'h2a, 8'h2a}, {REG_VB_F1_DUR, 8'h2b, 8'h2b},
    {REG_F0_FLAG, 8'h02, 8'h02}, {REG_F1_FLAG, 8'h01, 8'h01}, {8'h10, 8'h5a, 8'h00}};

  lpa_host_model host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
  lpa_line_timing dut (.clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .sync_n_in(sync_n_in),
    .reference_clock(reference_clock), .pll_cfg(pll_cfg), .vertical_blank(vertical_blank),
    .output_format(output_format), .pixel_count(pixel_count),
    .active_video_window(active_video_window), .sync_clean_n(sync_clean_n));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check_value(input logic [11:0] got, input logic [11:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_value

  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.write_reg(SLAVE_ADDR_DEF, a, d, ok);
    check_value({11'h0, ok}, 12'h001);
  endtask : wr

  task automatic wait_count(input logic [11:0] t, input int lim);
    int n;
    n = 0;
    while (pixel_count !== t && n < lim) begin
      @(negedge clk);
      n++;
    end
    check_value({11'h0, n < lim}, 12'h001);
    if (n >= lim) give_verdict();
  endtask : wait_count

  function automatic logic in_win(input logic [11:0] c);
    return (we < ws) ? (c >= ws || c < we) : (c >= ws && c < we);
  endfunction : in_win

  task automatic set_window(input logic [11:0] s, input logic [11:0] e);
    wr(REG_START_LOW, s[7:0]);
    wr(REG_START_HIGH, {4'h0, s[11:8]});
    wr(REG_STOP_LOW, e[7:0]);
    wr(REG_STOP_HIGH, {4'h0, e[11:8]});
    ws = s;
    we = e;
    @(negedge clk);
    mon_on = 1'b1;
    repeat (90) @(negedge clk);
    mon_on = 1'b0;
    $display("test window %h to %h done", s, e);
  endtask : set_window

  // Sync pulse at count 25, after a line end has reopened the window
  task automatic pulse_sync(input logic p);
    wait_count(DIV - 12'h001, 60);
    wait_count(12'h019, 60);
    @(posedge clk);
    sync_n_in <= 1'b0;
    if (p) begin
      wait_count(12'h000, 8);
      check_value({11'h0, sync_clean_n}, 12'h000);
    end else begin
      for (int k = 1; k <= 8; k++) begin
        @(negedge clk);
        check_value(pixel_count, 12'h019 + 12'(k));
        check_value({11'h0, sync_clean_n}, 12'h001);
      end
    end
    repeat (4) @(posedge clk);
    sync_n_in <= 1'b1;
    $display("test sync pulse pass=%0d done", p);
  endtask : pulse_sync

  always @(posedge clk) reference_clock <= ref_run & ~reference_clock;

  // Outputs are looked at on the falling edge, where they have settled
  always @(negedge clk) begin
    prev_cnt <= pixel_count;
    if (mon_on) begin
      check_value({11'h0, active_video_window}, {11'h0, in_win(prev_cnt)});
      check_value(pixel_count, (prev_cnt == DIV - 12'h001) ? 12'h000 : prev_cnt + 1'b1);
      check_value({11'h0, sda_out}, 12'h000);
    end
  end

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    reset = 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      host.read_reg(SLAVE_ADDR_DEF, rows[i][23:16], rd, ok);
      check_value({11'h0, ok}, 12'h001);
      check_value({4'h0, rd}, {4'h0, rows[i][7:0]});
    end
    check_value(pll_cfg.line_pixel_divider, DIV);
    check_value({11'h0, pll_cfg.output_divider}, 12'h001);
    check_value({4'h0, pll_cfg.stripper_width}, 12'h003);
    check_value({4'h0, vertical_blank.field0_offset}, 12'h005);
    check_value({4'h0, vertical_blank.field1_duration}, 12'h02b);
    check_value({4'h0, vertical_blank.field0_flag}, 12'h002);
    check_value({4'h0, output_format}, 12'h047);
    $display("test register rows done");
    host.write_reg(7'h11, REG_DIV_HIGH, 8'hff, ok);
    check_value({11'h0, ok}, 12'h000);
    check_value(pll_cfg.line_pixel_divider, DIV);
    for (int c = 0; c < 4; c++) begin
      wr(REG_RANGE_PUMP, {2'(c), 3'(7 - c), 3'h0});
      check_value({10'h0, pll_cfg.vco_range}, 12'(c));
      check_value({9'h0, pll_cfg.charge_pump_current}, 12'(7 - c));
    end
    wr(REG_OUT_DIVIDER, 8'h00);
    check_value({11'h0, pll_cfg.output_divider}, 12'h000);
    $display("test pll fields done");
    set_window(ST, SP);
    set_window(ST2, SP2);
    pulse_sync(1'b1);
    wr(REG_STRIP_CTRL, 8'h01);
    check_value({11'h0, pll_cfg.copy_guard_strip_enable}, 12'h001);
    pulse_sync(1'b0);
    @(negedge clk);
    ref_run = 1'b0;
    pulse_sync(1'b1);
    @(posedge clk);
    reset <= 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    check_value(pll_cfg.line_pixel_divider, 12'h000);
    check_value({11'h0, sync_clean_n}, 12'h001);
    check_value({11'h0, active_video_window}, 12'h000);
    host.read_reg(SLAVE_ADDR_DEF, REG_OUT_FORMAT, rd, ok);
    check_value({4'h0, rd}, 12'h000);
    // Status after reset: outside the window, stripper window open
    host.read_reg(SLAVE_ADDR_DEF, REG_STATUS, rd, ok);
    check_value({11'h0, ok}, 12'h001);
    check_value({4'h0, rd}, 12'h002);
    $display("test reset done");
    give_verdict();
  end
endmodule : test_line_pll_active_window_cfg
